/* File: common/mir_params.svh */
// layout constants and settle cycle count of the maskable interrupt request logic
`ifndef MIR_PARAMS_SVH
`define MIR_PARAMS_SVH
`define MIR_NSRC 8
`define MIR_LVL_W 3
`define MIR_ACK_ADDR 20'h0_0000
`define MIR_SP_RESET 16'h0000
`define MIR_FLAG_BIT 3
`define MIR_SETTLE_CYC 3
`endif

/* File: common/mir_pkg.sv */
// types of the maskable interrupt request logic
`default_nettype none
`include "mir_params.svh"
package mir_pkg;
    typedef logic [`MIR_NSRC-1:0] mir_vec_type;
    typedef logic [2:0] mir_idx_type;
    typedef logic [`MIR_LVL_W-1:0] mir_lvl_type;
    // kinds of write to an interrupt control register
    typedef enum logic [1:0] {
        MIR_WR_MOVE,
        MIR_WR_BITOP,
        MIR_WR_RMW
    } mir_wr_kind_type;
    // one core bus cycle
    typedef struct packed {
        logic rd;
        logic [19:0] addr;
    } mir_bus_type;
    // control register write request
    typedef struct packed {
        logic wr;
        mir_idx_type idx;
        mir_wr_kind_type kind;
        logic [7:0] data;
    } mir_ctl_wr_type;
    // interrupt information fetched by the core
    typedef struct packed {
        logic valid;
        mir_idx_type num;
        mir_lvl_type lvl;
    } mir_info_type;
endpackage
`default_nettype wire

/* File: core/mir_core.sv */
// maskable interrupt request logic: flags, priority, acknowledge, enable
//
// Contract
// - acknowledge fetch from address zero returns number, level; clears that flag
// - any read of address zero clears highest-priority enabled pending flag
// - reset clears the stack pointer to zero
// - changing source, polarity or timing may set the pending flag
// - bit-op writes keep a request arriving during the write
// - a full-register move writing zero clears the pending flag
// - no maskable interrupt accepted while the global enable flag is 0
// - enable-flag set waits for pending control writes to settle
`default_nettype none
`include "mir_params.svh"
module mir_core
    import mir_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // peripheral request strobes and source-change strobes
    input wire mir_vec_type src_req,
    input wire mir_vec_type src_change,
    // core bus
    input wire mir_bus_type bus,
    input wire mir_ctl_wr_type ctl_wr,
    input wire logic gie_set,
    input wire logic gie_clr,
    input wire logic sp_wr,
    input wire logic [15:0] sp_wdata,
    // towards the core
    output logic irq,
    output mir_info_type info,
    output logic gie,
    output logic [15:0] stack_pointer_reg,
    output mir_vec_type request_pending_flag
);
    // control register: [3] flag, [2:0] level; level 0 masks
    mir_vec_type flag_q, flag_d;
    mir_lvl_type lvl_q [`MIR_NSRC];
    mir_lvl_type lvl_d [`MIR_NSRC];
    logic gie_q, gie_d;
    logic gie_pend_q, gie_pend_d;
    logic [1:0] settle_q, settle_d;
    logic [15:0] sp_q, sp_d;
    mir_info_type info_q, info_d;
    // combinational helpers
    logic found;
    mir_idx_type win;
    mir_lvl_type win_lvl;
    logic ack_rd;
    logic wr_any;

    // a level of zero means the source is masked off
    function automatic logic lvl_enabled(input mir_lvl_type lvl);
        return lvl != '0;
    endfunction

    // strictly higher level wins; equal levels keep the earlier pick
    function automatic logic outranks(input mir_lvl_type cand,
            input mir_lvl_type best);
        return lvl_enabled(cand) && cand > best;
    endfunction

    // a read cycle on the interrupt information address
    function automatic logic is_info_read(input mir_bus_type b);
        return b.rd && b.addr == `MIR_ACK_ADDR;
    endfunction

    // does this write to source i drop a same-cycle request
    function automatic logic drops_req(input mir_ctl_wr_type w,
            input mir_idx_type i);
        return w.wr && w.idx == i && w.kind == MIR_WR_RMW;
    endfunction

    // higher level wins, lower index breaks ties; a fixed scan keeps
    // the choice stable while several requests wait
    always_comb begin
        found = 1'b0;
        win = '0;
        win_lvl = '0;
        for (int i = 0; i < `MIR_NSRC; i++) begin
            if (flag_q[i] && outranks(lvl_q[i], win_lvl)) begin
                found = 1'b1;
                win = mir_idx_type'(i);
                win_lvl = lvl_q[i];
            end
        end
    end

    // the core's fetch and a stray program read look the same here,
    // so both consume the winning request
    assign ack_rd = is_info_read(bus);
    assign wr_any = ctl_wr.wr;

    // pending flags: acknowledge clears, move writes, requests set last
    always_comb begin
        flag_d = flag_q;
        if (ack_rd && found) begin
            flag_d[win] = 1'b0;
        end
        // only a move may clear; bit ops leave the flag alone
        if (wr_any && ctl_wr.kind == MIR_WR_MOVE) begin
            flag_d[ctl_wr.idx] = ctl_wr.data[`MIR_FLAG_BIT];
        end
        // set wins over clear, except a rmw rewrite of the same
        // register, which writes the old flag back over the request
        for (int i = 0; i < `MIR_NSRC; i++) begin
            if (src_req[i] || src_change[i]) begin
                if (!drops_req(ctl_wr, mir_idx_type'(i))) begin
                    flag_d[i] = 1'b1;
                end
            end
        end
    end

    // pending flags register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // priority levels follow every write kind
    always_comb begin
        lvl_d = lvl_q;
        if (wr_any) begin
            lvl_d[ctl_wr.idx] = ctl_wr.data[`MIR_LVL_W-1:0];
        end
    end

    // priority levels register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < `MIR_NSRC; i++) begin
                lvl_q[i] <= '0;
            end
        end else begin
            lvl_q <= lvl_d;
        end
    end

    // settle counter restarts on every control write
    always_comb begin
        settle_d = settle_q;
        if (wr_any) begin
            settle_d = 2'(`MIR_SETTLE_CYC);
        end else if (settle_q != '0) begin
            settle_d = settle_q - 2'd1;
        end
    end

    // enable set is held back until control writes have settled, so a
    // too-early set cannot let a stale request through; clear wins
    always_comb begin
        gie_d = gie_q;
        gie_pend_d = gie_pend_q;
        if (gie_clr) begin
            gie_d = 1'b0;
            gie_pend_d = 1'b0;
        end else if (gie_set || gie_pend_q) begin
            if (settle_d == '0 && !wr_any) begin
                gie_d = 1'b1;
                gie_pend_d = 1'b0;
            end else begin
                gie_pend_d = 1'b1;
            end
        end
    end

    // settle and enable registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            settle_q <= '0;
            gie_q <= 1'b0;
            gie_pend_q <= 1'b0;
        end else begin
            settle_q <= settle_d;
            gie_q <= gie_d;
            gie_pend_q <= gie_pend_d;
        end
    end

    // stack pointer: software must load it before the first acknowledge
    always_comb begin
        sp_d = sp_q;
        if (sp_wr) begin
            sp_d = sp_wdata;
        end
    end

    // stack pointer register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sp_q <= `MIR_SP_RESET;
        end else begin
            sp_q <= sp_d;
        end
    end

    // information word, valid for one cycle after the fetch
    always_comb begin
        info_d = '0;
        if (ack_rd && found) begin
            info_d = '{valid: 1'b1, num: win, lvl: win_lvl};
        end
    end

    // information register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            info_q <= '0;
        end else begin
            info_q <= info_d;
        end
    end

    // outputs straight from the registers, except irq, which gates the combinational winner search with the enable
    assign irq = gie_q && found;
    assign info = info_q;
    assign gie = gie_q;
    assign stack_pointer_reg = sp_q;
    assign request_pending_flag = flag_q;
endmodule
`default_nettype wire

/* File: bench/mir_core_sva.sv */
// checker for the interrupt request ports
`default_nettype none
module mir_core_sva import mir_pkg::*; (
    // watched ports
    input wire logic clk, rst_b, irq, gie,
    input wire mir_vec_type src_req, src_change, request_pending_flag,
    input wire mir_bus_type bus, input wire mir_ctl_wr_type ctl_wr,
    input wire mir_info_type info,
    input wire logic [15:0] stack_pointer_reg);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // zero reads; cycles that bring no new set source
    wire logic ack = bus.rd && bus.addr == 20'h0_0000;
    wire logic calm = !src_req && !src_change;
    a_sp_zero: assert property ($rose(rst_b) |-> !stack_pointer_reg)
        else $error("sp");
    a_ack_info: assert property (ack && irq |=> info.valid)
        else $error("info");
    a_ack_clear: assert property (ack && irq && calm && !ctl_wr.wr
        |=> $onehot(request_pending_flag ^ $past(request_pending_flag)))
        else $error("flag");
    a_gie_gate: assert property (!gie |-> !irq) else $error("irq");
    a_chg_set: assert property (src_change[3] && !bus.rd
        |=> request_pending_flag[3]) else $error("chg");
    a_bitop_keep: assert property (src_req[3] && ctl_wr.wr && !bus.rd
        && ctl_wr.kind == MIR_WR_BITOP |=> request_pending_flag[3])
        else $error("lost");
    a_move_clear: assert property (ctl_wr.wr && !ctl_wr.data[3] && calm
        && ctl_wr.kind == MIR_WR_MOVE
        |=> !request_pending_flag[$past(ctl_wr.idx)]) else $error("kept");
    a_gie_settle: assert property (ctl_wr.wr && !gie |=> (!gie) [*2])
        else $error("gie");
endmodule
bind mir_core mir_core_sva mir_core_sva_inst (.*);
`default_nettype wire

/* File: bench/mir_core_partner.sv */
// core model that fetches interrupt information at address zero
`default_nettype none
module mir_core_partner import mir_pkg::*; (
    // clock, mode and device side
    input wire logic clk, en, slow, irq,
    input wire mir_info_type info,
    output var mir_bus_type bus, output var mir_idx_type num);
    timeunit 1ns; timeprecision 1ns;
    logic w_q = 1'b0;
    // one fetch per request shown; a slow core idles a cycle first
    always @(posedge clk) begin
        w_q <= en && irq && !bus.rd;
        bus <= {en && irq && !bus.rd && (w_q || !slow), 20'h0_0000};
        if (info.valid) num <= info.num;
    end
endmodule
`default_nettype wire

/* File: bench/mir_core_bench.sv */
// bench for the interrupt request logic
`default_nettype none
module mir_core_bench import mir_pkg::*;;
    timeunit 1ns; timeprecision 1ns;
    logic clk = 0, rst_b = 0, gie_set = 0, gie_clr = 0, sp_wr = 0, pen = 0;
    logic slow = 0, irq, gie;
    logic [15:0] sp_wdata = 16'h1234, sp;
    mir_vec_type src_req = '0, src_change = '0, fl;
    mir_bus_type tb = '0, cb, bus;
    mir_ctl_wr_type ctl_wr = '0;
    mir_info_type info;
    mir_idx_type num;
    int err_count = 0, total_checks = 0;
    // the core model owns the bus while it acknowledges
    assign bus = pen ? cb : tb;
    always #5 clk = ~clk;
    mir_core mir_core_inst (.*, .request_pending_flag(fl),
        .stack_pointer_reg(sp));
    mir_core_partner mir_core_partner_inst (.clk, .en(pen), .slow, .irq,
        .info, .bus(cb), .num);
    task step(int n); repeat (n) @(posedge clk); #1; endtask
    task chk(logic [15:0] g, e); total_checks++;
        if (g !== e) begin err_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task give_verdict;
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task t_sp; chk(sp, 16'h0000);
        sp_wr = 1; step(1); sp_wr = 0; chk(sp, 16'h1234); endtask
    task t_lvl; gie_set = 1;
        for (int i = 0; i < 8; i++) begin
            ctl_wr = {1'b1, i[2:0], MIR_WR_MOVE, 5'h00, i[2:0]};
            step(1); gie_set = 0; end
        ctl_wr = '0; step(1); chk(gie, 1'b0);
        step(4); chk(gie, 1'b1); endtask
    task t_prio; src_req = 8'h24; step(1); src_req = '0; pen = 1;
        chk(fl, 8'h24); step(3); chk(num, 3'h5);
        step(2); chk(num, 3'h2); chk(fl, 8'h00); pen = 0; endtask
    task t_read; src_req = 8'h50; step(1); src_req = '0; tb.rd = 1;
        step(1); chk(fl, 8'h10);
        chk(info, {1'b1, 3'h6, 3'h6});
        step(1); tb.rd = 0; chk(fl, 8'h00); endtask
    task t_src; src_change = 8'h08; step(1); src_change = '0;
        chk(fl, 8'h08);
        ctl_wr = {1'b1, 3'h3, MIR_WR_MOVE, 8'h03}; step(1);
        chk(fl, 8'h00);
        ctl_wr.kind = MIR_WR_BITOP; src_req = 8'h08; step(1);
        ctl_wr = '0; src_req = '0; chk(fl, 8'h08);
        ctl_wr = {1'b1, 3'h3, MIR_WR_MOVE, 8'h03}; step(1);
        ctl_wr.kind = MIR_WR_RMW; src_req = 8'h08; step(1);
        ctl_wr = '0; chk(fl, 8'h00); step(1);
        src_req = '0; chk(fl, 8'h08);
        pen = 1; slow = 1; step(5); chk(num, 3'h3);
        pen = 0; gie_clr = 1; src_req = 8'h08; step(1);
        gie_clr = 0; src_req = '0; chk(gie, 1'b0);
        chk(irq, 1'b0); chk(fl, 8'h08); endtask
    // reset for ten cycles, then each scenario in turn
    initial begin step(10); rst_b = 1;
        t_sp; t_lvl; t_prio; t_read; t_src; give_verdict; end
    // watchdog: the sequence needs well under this span
    initial begin #3000; err_count++; give_verdict; end
endmodule
`default_nettype wire
